/* File: hdl/gate_pkg.sv */
// constants and types for the gate operator sequencer
package gate_pkg;
   localparam int unsigned CLK_HZ          = 250_000_000;
   localparam int unsigned TICK_CYCLES     = CLK_HZ / 10;  // 100 ms timing tick
   localparam int unsigned TICKS_PER_S     = 10;
   localparam int unsigned AUTO_CLOSE_MAX_S = 124;
   localparam int unsigned RUN_MIN_S       = 15;
   localparam int unsigned RUN_MAX_S       = 100;
   localparam int unsigned PREWARN_MS      = 2000;
   localparam int unsigned LOCK_DELAY_MS   = 1000;
   localparam int unsigned REV_LONG_MS     = 3000;
   localparam int unsigned REV_SHORT_MS    = 1500;
   localparam int unsigned BACKOFF_MS      = 1000;
   localparam int unsigned PREWARN_TICKS   = PREWARN_MS / 100;
   localparam int unsigned LOCK_TICKS      = LOCK_DELAY_MS / 100;
   localparam int unsigned REV_LONG_TICKS  = REV_LONG_MS / 100;
   localparam int unsigned REV_SHORT_TICKS = REV_SHORT_MS / 100;
   localparam int unsigned BACKOFF_TICKS   = BACKOFF_MS / 100;
   localparam int unsigned DEBOUNCE_CYCLES = 250_000;       // 1 ms stable
   // config switch positions
   localparam int unsigned SW_AUTO_CLOSE = 0;
   localparam int unsigned SW_PREWARN    = 1;
   localparam int unsigned SW_CYCLIC     = 2;
   localparam int unsigned SW_LEFT_HAND  = 3;
   localparam int unsigned SW_LOCK_DELAY = 4;
   localparam int unsigned SW_LONG_REV   = 5;
   localparam int unsigned SW_UNUSED     = 6;
   localparam int unsigned SW_SLAVE      = 7;
   // debounced input bit positions
   localparam int unsigned IN_OPEN   = 0;
   localparam int unsigned IN_CLOSE  = 1;
   localparam int unsigned IN_SINGLE = 2;
   localparam int unsigned IN_STOP_N = 3;
   localparam int unsigned IN_REV    = 4;
   localparam int unsigned IN_HOLD   = 5;
   localparam int unsigned IN_LIM_O  = 6;
   localparam int unsigned IN_LIM_C  = 7;
   localparam int unsigned IN_OBS_O  = 8;
   localparam int unsigned IN_OBS_C  = 9;
   localparam int unsigned IN_COUNT  = 10;
   localparam logic [IN_COUNT-1:0] IN_RESET = 10'h008;  // stop circuit idles closed

   typedef enum logic [1:0] {DIR_NONE, DIR_OPEN, DIR_CLOSE} dir_t;
   typedef enum logic [1:0] {CYC_OPEN, CYC_STOP1, CYC_CLOSE, CYC_STOP2} cyc_t;

   // motor drive outputs grouped together
   typedef struct packed {
      logic run;
      logic fwd;
      logic rev;
      logic brake_en;
   } motor_t;
endpackage : gate_pkg

/* File: hdl/gate_operator_sequencer.sv */
// sequencer for a motorised sliding gate operator
`timescale 1ns/1ns
`default_nettype none
module gate_operator_sequencer #(
   parameter int unsigned TICK_CYCLES     = gate_pkg::TICK_CYCLES,
   parameter int unsigned DEBOUNCE_CYCLES = gate_pkg::DEBOUNCE_CYCLES
) (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          sys_rst,
   // pushbuttons and sensors, raw from pins
   input  wire logic                          open_btn,
   input  wire logic                          close_btn,
   input  wire logic                          single_btn,
   input  wire logic                          stop_n,
   input  wire logic                          reverse_in,
   input  wire logic                          hold_in,
   input  wire logic                          open_limit_switch,
   input  wire logic                          close_limit_switch,
   // motor current comparators and their thresholds
   input  wire logic [9:0]                    motor_current,
   input  wire logic [9:0]                    open_sense_level,
   input  wire logic [9:0]                    close_sense_level,
   // configuration switches and timer settings (seconds)
   input  wire logic [7:0]                    config_sw,
   input  wire logic [6:0]                    auto_close_s,
   input  wire logic [6:0]                    max_run_s,
   // master/slave paired command
   input  wire logic                          peer_open,
   input  wire logic                          peer_close,
   // outputs
   output var  gate_pkg::motor_t              motor,
   output logic                               lock_release,
   output logic                               warning_out,
   output logic                               alarm_out,
   output logic                               lockout,
   output logic                               slave_mode,
   output logic                               fully_open,
   output logic                               peer_cmd_open,
   output logic                               peer_cmd_close
);

   typedef enum logic [3:0] {
      ST_IDLE, ST_PREWARN, ST_UNLOCK, ST_RUN, ST_PAUSE, ST_BACKOFF, ST_LOCKED
   } state_t;

   state_t                       state;
   gate_pkg::dir_t               dir;
   gate_pkg::dir_t               pend_dir;
   gate_pkg::cyc_t               cyc;
   logic [gate_pkg::IN_COUNT-1:0] raw;
   logic [gate_pkg::IN_COUNT-1:0] sync1;
   logic [gate_pkg::IN_COUNT-1:0] sync2;
   logic [gate_pkg::IN_COUNT-1:0] deb;
   logic [gate_pkg::IN_COUNT-1:0] deb_q;
   logic [31:0]                  tick_cnt;
   logic                         tick;
   logic [10:0]                  phase_cnt;
   logic [10:0]                  run_cnt;
   logic [10:0]                  ac_cnt;
   logic                         ac_armed;
   logic                         obs_strike;
   logic                         obs_o;
   logic                         obs_c;
   logic                         single_rise;
   logic                         open_req;
   logic                         close_req;
   logic [10:0]                  run_limit;
   logic [10:0]                  ac_limit;
   logic [6:0]                   run_s;
   logic [6:0]                   ac_s;

   // current comparators become sensor bits; separate threshold per direction
   assign obs_o = (motor_current > open_sense_level);
   assign obs_c = (motor_current > close_sense_level);
   assign raw = {obs_c, obs_o, close_limit_switch, open_limit_switch, hold_in,
                 reverse_in, stop_n, single_btn, close_btn | peer_close,
                 open_btn | peer_open};

   // two-stage synchronisers; first stage read only by second
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1 <= gate_pkg::IN_RESET;
         sync2 <= gate_pkg::IN_RESET;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
      end
   end

   // per-input debounce: accept a level only after it holds steady
   generate
      for (genvar i = 0; i < gate_pkg::IN_COUNT; i++) begin : g_deb
         logic [31:0] stable_cnt;
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               stable_cnt <= 32'h0;
               deb[i]     <= gate_pkg::IN_RESET[i];
            end else if (sync2[i] == deb[i]) begin
               stable_cnt <= 32'h0;
            end else if (stable_cnt >= DEBOUNCE_CYCLES - 1) begin
               stable_cnt <= 32'h0;
               deb[i]     <= sync2[i];
            end else begin
               stable_cnt <= stable_cnt + 32'h1;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) deb_q <= gate_pkg::IN_RESET;
      else         deb_q <= deb;
   end

   // 100 ms tick enable; coarse grain is plenty for second-scale timers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick_cnt <= 32'h0;
         tick     <= 1'b0;
      end else begin
         tick     <= (tick_cnt == TICK_CYCLES - 1);
         tick_cnt <= (tick_cnt == TICK_CYCLES - 1) ? 32'h0 : tick_cnt + 32'h1;
      end
   end

   // clamp settings into their documented ranges
   assign ac_s  = (auto_close_s > 7'(gate_pkg::AUTO_CLOSE_MAX_S)) ?
                  7'(gate_pkg::AUTO_CLOSE_MAX_S) : auto_close_s;
   assign run_s = (max_run_s < 7'(gate_pkg::RUN_MIN_S)) ? 7'(gate_pkg::RUN_MIN_S) :
                  (max_run_s > 7'(gate_pkg::RUN_MAX_S)) ? 7'(gate_pkg::RUN_MAX_S) :
                  max_run_s;
   assign ac_limit  = 11'(ac_s * gate_pkg::TICKS_PER_S);
   assign run_limit = 11'(run_s * gate_pkg::TICKS_PER_S);

   // command decode; switch six is never looked at
   assign single_rise = deb[gate_pkg::IN_SINGLE] & ~deb_q[gate_pkg::IN_SINGLE];
   always_comb begin
      open_req  = deb[gate_pkg::IN_OPEN] & ~deb_q[gate_pkg::IN_OPEN];
      close_req = deb[gate_pkg::IN_CLOSE] & ~deb_q[gate_pkg::IN_CLOSE];
      if (single_rise) begin
         if (config_sw[gate_pkg::SW_CYCLIC]) begin
            open_req  = open_req | (cyc == gate_pkg::CYC_OPEN);
            close_req = close_req | (cyc == gate_pkg::CYC_CLOSE);
         end else if (fully_open) begin
            close_req = 1'b1;
         end else begin
            open_req = 1'b1;
         end
      end
   end

   // single-button cycle position; stop steps also halt the gate below
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) cyc <= gate_pkg::CYC_OPEN;
      else if (single_rise && config_sw[gate_pkg::SW_CYCLIC]) cyc <= gate_pkg::cyc_t'(cyc + 2'h1);
   end

   // fully-open flag from the debounced limit for the open travel
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) fully_open <= 1'b0;
      else         fully_open <= deb[gate_pkg::IN_LIM_O];
   end

   // main sequence: prewarn, lock release, run, reverse pause, back-off, lockout
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state      <= ST_IDLE;
         dir        <= gate_pkg::DIR_NONE;
         pend_dir   <= gate_pkg::DIR_NONE;
         phase_cnt  <= 11'h0;
         run_cnt    <= 11'h0;
         obs_strike <= 1'b0;
         ac_armed   <= 1'b1;
      end else if (state == ST_LOCKED) begin
         state <= ST_LOCKED;              // only reset clears lockout
      end else if (!deb[gate_pkg::IN_STOP_N] ||
                   (single_rise && config_sw[gate_pkg::SW_CYCLIC] &&
                    (cyc == gate_pkg::CYC_STOP1 || cyc == gate_pkg::CYC_STOP2))) begin
         state <= ST_IDLE;
         dir   <= gate_pkg::DIR_NONE;
      end else begin
         if (tick && phase_cnt != 11'h0) phase_cnt <= phase_cnt - 11'h1;
         case (state)
            ST_IDLE: begin
               if ((open_req || deb[gate_pkg::IN_HOLD]) && !fully_open) begin
                  pend_dir <= gate_pkg::DIR_OPEN;
                  state    <= ST_PREWARN;
                  ac_armed <= 1'b1;
                  phase_cnt <= config_sw[gate_pkg::SW_PREWARN] ?
                               11'(gate_pkg::PREWARN_TICKS) : 11'h0;
               end else if ((close_req || (config_sw[gate_pkg::SW_AUTO_CLOSE] && ac_armed
                            && fully_open && ac_cnt >= ac_limit && !deb[gate_pkg::IN_OPEN]
                            && !deb[gate_pkg::IN_REV] && !deb[gate_pkg::IN_OBS_O]
                            && !deb[gate_pkg::IN_OBS_C])) && !deb[gate_pkg::IN_HOLD]
                            && !deb[gate_pkg::IN_LIM_C]) begin
                  pend_dir <= gate_pkg::DIR_CLOSE;
                  state    <= ST_PREWARN;
                  phase_cnt <= config_sw[gate_pkg::SW_PREWARN] ?
                               11'(gate_pkg::PREWARN_TICKS) : 11'h0;
               end
            end
            ST_PREWARN: if (phase_cnt == 11'h0) begin
               state     <= ST_UNLOCK;
               phase_cnt <= config_sw[gate_pkg::SW_LOCK_DELAY] ?
                            11'(gate_pkg::LOCK_TICKS) : 11'h0;
            end
            ST_UNLOCK: if (phase_cnt == 11'h0) begin
               state   <= ST_RUN;
               dir     <= pend_dir;
               run_cnt <= run_limit;
            end
            ST_RUN: begin
               if (tick && run_cnt != 11'h0) run_cnt <= run_cnt - 11'h1;
               if ((dir == gate_pkg::DIR_OPEN && deb[gate_pkg::IN_LIM_O]) ||
                   (dir == gate_pkg::DIR_CLOSE && deb[gate_pkg::IN_LIM_C])) begin
                  state      <= ST_IDLE;
                  dir        <= gate_pkg::DIR_NONE;
                  obs_strike <= 1'b0;
               end else if ((dir == gate_pkg::DIR_OPEN && deb[gate_pkg::IN_OBS_O]) ||
                            (dir == gate_pkg::DIR_CLOSE && deb[gate_pkg::IN_OBS_C])) begin
                  ac_armed <= 1'b0;
                  dir      <= gate_pkg::DIR_NONE;
                  if (obs_strike) begin
                     state <= ST_LOCKED;
                  end else begin
                     obs_strike <= 1'b1;
                     pend_dir   <= (dir == gate_pkg::DIR_OPEN) ?
                                   gate_pkg::DIR_CLOSE : gate_pkg::DIR_OPEN;
                     state      <= ST_PAUSE;
                     phase_cnt  <= 11'(gate_pkg::BACKOFF_TICKS);
                  end
               end else if (run_cnt == 11'h0) begin
                  state <= ST_LOCKED;
                  dir   <= gate_pkg::DIR_NONE;
               end else if ((dir == gate_pkg::DIR_CLOSE && (deb[gate_pkg::IN_REV] ||
                             open_req)) || (dir == gate_pkg::DIR_OPEN && close_req)) begin
                  pend_dir  <= (dir == gate_pkg::DIR_OPEN) ?
                               gate_pkg::DIR_CLOSE : gate_pkg::DIR_OPEN;
                  dir       <= gate_pkg::DIR_NONE;
                  state     <= ST_PAUSE;
                  phase_cnt <= config_sw[gate_pkg::SW_LONG_REV] ?
                               11'(gate_pkg::REV_LONG_TICKS) :
                               11'(gate_pkg::REV_SHORT_TICKS);
               end
            end
            ST_PAUSE: if (phase_cnt == 11'h0) begin
               dir     <= pend_dir;
               run_cnt <= run_limit;
               if (obs_strike && !ac_armed) begin
                  state     <= ST_BACKOFF;
                  phase_cnt <= 11'(gate_pkg::BACKOFF_TICKS);
               end else begin
                  state <= ST_RUN;
               end
            end
            ST_BACKOFF: if (phase_cnt == 11'h0) begin
               state    <= ST_IDLE;
               dir      <= gate_pkg::DIR_NONE;
               ac_armed <= 1'b0;
            end
            default: state <= ST_IDLE;
         endcase
         // a backed-off gate needs a fresh command; keep strike until a limit
         if (state == ST_BACKOFF && phase_cnt == 11'h0) ac_armed <= 1'b0;
      end
   end

   // auto-close dwell timer counts while parked at full open
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) ac_cnt <= 11'h0;
      else if (state != ST_IDLE || !fully_open || deb[gate_pkg::IN_HOLD]) ac_cnt <= 11'h0;
      else if (tick && ac_cnt != 11'h7FF) ac_cnt <= ac_cnt + 11'h1;
   end

   // registered outputs; handedness maps logical direction onto motor leads
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         motor          <= '0;
         lock_release   <= 1'b0;
         warning_out    <= 1'b0;
         alarm_out      <= 1'b0;
         lockout        <= 1'b0;
         slave_mode     <= 1'b0;
         peer_cmd_open  <= 1'b0;
         peer_cmd_close <= 1'b0;
      end else begin
         motor.run  <= (dir != gate_pkg::DIR_NONE);
         motor.fwd  <= (dir == gate_pkg::DIR_OPEN) ^ config_sw[gate_pkg::SW_LEFT_HAND] &
                       (dir != gate_pkg::DIR_NONE);
         motor.rev  <= (dir == gate_pkg::DIR_CLOSE) ^ config_sw[gate_pkg::SW_LEFT_HAND] &
                       (dir != gate_pkg::DIR_NONE);
         motor.brake_en <= !config_sw[gate_pkg::SW_LONG_REV];
         lock_release   <= (state == ST_UNLOCK) || (dir != gate_pkg::DIR_NONE);
         warning_out    <= (dir != gate_pkg::DIR_NONE) ||
                           (state == ST_PREWARN && config_sw[gate_pkg::SW_PREWARN]);
         alarm_out      <= (state == ST_LOCKED);
         lockout        <= (state == ST_LOCKED);
         slave_mode     <= config_sw[gate_pkg::SW_SLAVE];
         peer_cmd_open  <= !config_sw[gate_pkg::SW_SLAVE] && dir == gate_pkg::DIR_OPEN;
         peer_cmd_close <= !config_sw[gate_pkg::SW_SLAVE] && dir == gate_pkg::DIR_CLOSE;
      end
   end

   // run timer expiry must lock within two cycles
   a_run_expiry_lock: assert property (@(posedge clk) disable iff (sys_rst)
      (state == ST_RUN && run_cnt == 11'h0 && !deb[gate_pkg::IN_LIM_O] && !deb[gate_pkg::IN_LIM_C]
       && !deb[gate_pkg::IN_OBS_O] && !deb[gate_pkg::IN_OBS_C] && deb[gate_pkg::IN_STOP_N])
      |=> ##1 lockout) else $error("run timer expiry did not lock out");
   a_limit_stops_motor: assert property (@(posedge clk) disable iff (sys_rst)
      (state == ST_RUN && dir == gate_pkg::DIR_OPEN && deb[gate_pkg::IN_LIM_O])
      |=> ##1 !motor.run) else $error("motor ran past open limit");
   a_stop_halts: assert property (@(posedge clk) disable iff (sys_rst)
      (!deb[gate_pkg::IN_STOP_N] && state != ST_LOCKED) |=> ##1 !motor.run)
      else $error("stop input did not halt motor");
   a_warn_while_run: assert property (@(posedge clk) disable iff (sys_rst)
      motor.run |-> warning_out) else $error("warning off while running");
   a_prewarn_gap: assert property (@(posedge clk) disable iff (sys_rst)
      ($rose(state == ST_PREWARN) && config_sw[gate_pkg::SW_PREWARN]) |=> !motor.run [*4])
      else $error("motor started without prewarning");
   a_alarm_lockout: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(lockout) |-> alarm_out && !motor.run) else $error("lockout without alarm");
   a_brake_setting: assert property (@(posedge clk) disable iff (sys_rst)
      $stable(config_sw) |=> motor.brake_en == !$past(config_sw[gate_pkg::SW_LONG_REV]))
      else $error("brake enable wrong");
   a_one_direction: assert property (@(posedge clk) disable iff (sys_rst)
      !(motor.fwd && motor.rev)) else $error("both motor directions driven");

endmodule : gate_operator_sequencer
`default_nettype wire

/* File: tb/gate_model.sv */
// gate mechanics model: travel position, limit switches, motor current
`timescale 1ns/1ns
`default_nettype none
module gate_model (
   // clock and motor drive from the sequencer, handedness and jam control from the bench
   input  wire logic             clk,
   input  wire gate_pkg::motor_t motor,
   input  wire logic             left_hand,
   input  wire logic             stall,
   // sensed outputs back to the sequencer
   output logic                  open_limit_switch,
   output logic                  close_limit_switch,
   output logic [9:0]            motor_current
);
   int   pos = 0;
   logic opening;
   // which winding opens depends on the side the operator is mounted on
   assign opening = left_hand ? motor.rev : motor.fwd;
   // one step a cycle, 100 steps end to end; a jammed gate does not move
   always @(posedge clk) begin
      if (motor.run && !stall && opening && pos < 100)
         pos <= pos + 1;
      else if (motor.run && !stall && !opening && pos > 0)
         pos <= pos - 1;
   end
   // limits stay made while the gate rests against the end stop
   assign open_limit_switch  = (pos >= 100);
   assign close_limit_switch = (pos <= 0);
   assign motor_current      = motor.run ? 10'h040 : 10'h000;
endmodule // gate_model
`default_nettype wire

/* File: tb/tb_gate_operator_sequencer.sv */
// self-checking bench for the gate operator sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_gate_operator_sequencer;
   logic clk = 1'b0, sys_rst = 1'b1, stop_n = 1'b1, stall = 1'b0, hold = 1'b0;
   logic [2:0] btns = 3'h0;
   logic [7:0] config_sw = 8'h02;
   logic [6:0] auto_close_s = 7'h01, max_run_s = 7'h0F;
   logic lim_o, lim_c, warning_out, alarm_out, lockout, fully_open;
   logic [9:0] cur;
   gate_pkg::motor_t motor;
   int failures = 0, total_checks = 0, n;
   gate_operator_sequencer #(.TICK_CYCLES(10), .DEBOUNCE_CYCLES(2)) u_gate_operator_sequencer (
      .clk(clk), .sys_rst(sys_rst), .open_btn(btns[0]), .close_btn(btns[1]),
      .single_btn(btns[2]), .stop_n(stop_n), .reverse_in(1'b0), .hold_in(hold),
      .open_limit_switch(lim_o), .close_limit_switch(lim_c), .motor_current(cur),
      .open_sense_level(10'h3FF), .close_sense_level(10'h3FF), .config_sw(config_sw),
      .auto_close_s(auto_close_s), .max_run_s(max_run_s), .peer_open(1'b0),
      .peer_close(1'b0), .motor(motor), .lock_release(), .warning_out(warning_out),
      .alarm_out(alarm_out), .lockout(lockout), .slave_mode(), .fully_open(fully_open),
      .peer_cmd_open(), .peer_cmd_close());
   gate_model u_gate_model (.clk(clk), .motor(motor), .left_hand(config_sw[3]),
      .stall(stall), .open_limit_switch(lim_o), .close_limit_switch(lim_c),
      .motor_current(cur));
   // 250 MHz clock
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   // buttons are held long enough to pass the input filter
   task automatic press(input logic [2:0] b);
      btns <= b;
      repeat (8) @(posedge clk);
      btns <= 3'h0;
   endtask
   // bounded wait on the run output, sampled after each edge settles
   task automatic wait_run(input logic v, input int limit);
      n = 0;
      while (motor.run !== v && n < limit) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   task automatic t_open_prewarn();
      press(3'h1);
      #1;
      check(warning_out, 32'h1);
      check(motor.run, 32'h0);
      wait_run(1'b1, 400);
      check(32'(n >= 180 && n <= 210), 32'h1);
      check({warning_out, motor.fwd, motor.rev}, 32'h6);
      wait_run(1'b0, 300);
      check({lim_o, fully_open}, 32'h3);
      repeat (150) @(posedge clk);
      check(motor.run, 32'h0);
      $display("test open_prewarn done");
   endtask
   task automatic t_auto_close();
      // hold must be through the input filter before auto close is enabled
      hold <= 1'b1;
      repeat (10) @(posedge clk);
      config_sw <= 8'h01;
      wait_run(1'b1, 130);
      check(motor.run, 32'h0);
      hold <= 1'b0;
      wait_run(1'b1, 130);
      check(32'(n > 0 && n < 130), 32'h1);
      check({warning_out, motor.fwd, motor.rev}, 32'h5);
      wait_run(1'b0, 300);
      check(lim_c, 32'h1);
      $display("test auto_close done");
   endtask
   task automatic t_stop_left();
      config_sw <= 8'h08;
      press(3'h1);
      wait_run(1'b1, 200);
      check({motor.fwd, motor.rev}, 32'h1);
      repeat (20) @(posedge clk);
      stop_n <= 1'b0;
      wait_run(1'b0, 20);
      check(32'(n < 12), 32'h1);
      stop_n <= 1'b1;
      $display("test stop_left done");
   endtask
   task automatic t_max_run();
      config_sw <= 8'h00;
      stall <= 1'b1;
      press(3'h1);
      wait_run(1'b1, 200);
      wait_run(1'b0, 1700);
      check(32'(n >= 1490 && n <= 1510), 32'h1);
      check({alarm_out, lockout}, 32'h3);
      press(3'h1);
      wait_run(1'b1, 300);
      check(motor.run, 32'h0);
      $display("test max_run done");
   endtask
   task automatic finish_test();
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // main sequence after a five-cycle reset
   initial begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (10) @(posedge clk);
      t_open_prewarn();
      t_auto_close();
      t_stop_left();
      t_max_run();
      finish_test();
   end
   // watchdog well beyond the expected run of about 2700 cycles
   initial begin
      repeat (30000) @(posedge clk);
      failures++;
      finish_test();
   end
endmodule // tb_gate_operator_sequencer
`default_nettype wire
